// >>> include/xfi_defines.vh
`ifndef XFI_DEFINES_VH
`define XFI_DEFINES_VH

// wishbone register byte offsets
`define XFI_REG_STATUS     8'h00
`define XFI_REG_CLEAR      8'h04
`define XFI_REG_ENABLE     8'h08
`define XFI_REG_MODES      8'h0C
`define XFI_REG_FLAGS      8'h10
`define XFI_REG_FPSTAT     8'h14
`define XFI_REG_PROG       8'h18
`define XFI_REG_SAVED_FLAGS 8'h1C
`define XFI_REG_SAVED_STAT 8'h20

// event bits of status, clear and enable
`define XFI_EV_ERR_EXIT    0
`define XFI_EV_NORM_EXIT   1
`define XFI_EV_FLOAT_ERR   2
`define XFI_EV_EXCH_DONE   3
`define XFI_EV_BITS        4

// interrupt-modes field bits
`define XFI_MODE_ERR_EXIT_EN  0
`define XFI_MODE_NORM_EXIT_EN 1
`define XFI_MODE_FLOAT_EN     2
`define XFI_MODE_GLOBAL_EN    3
`define XFI_MODE_BITS      4
`define XFI_MODE_RESET     4'h0

// interrupt-flags field bits
`define XFI_FLAG_ERR_EXIT  0
`define XFI_FLAG_NORM_EXIT 1
`define XFI_FLAG_FLOAT_ERR 2
`define XFI_FLAG_BITS      3

// status field bits
`define XFI_STAT_FLOAT_ERR 0

// issued opcodes, 16-bit parcel (octal 000000 and 004000)
`define XFI_OP_ERR_EXIT    16'h0000
`define XFI_OP_NORM_EXIT   16'h0800

// context block layout, word indices
`define XFI_CTX_WORDS      16
`define XFI_CTX_W_MODES    4'h1
`define XFI_CTX_W_FLAGS    4'h2
`define XFI_CTX_W_STATUS   4'h3

`endif

// >>> core/xfi_ctx_mem.v
`timescale 1ns/1ps

module xfi_ctx_mem #(
  parameter DW = 32,
  parameter AW = 6
) (
  input  wire          clock,
  input  wire          clk_en,
  input  wire          wr_en,
  input  wire          rd_en,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata_q
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clock) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[addr] <= wdata;
      end
      if (rd_en) begin
        rdata_q <= mem[addr];
      end
    end
  end

endmodule // xfi_ctx_mem

// >>> core/xfi_exit_flags.v
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "xfi_defines.vh"
// Function
// - each program owns a sixteen-word context block used by the exchange.
// - error exit sets its flag when its mode bit and global enable are set.
// - normal exit sets its flag when the normal-exit mode bit is set.
// - normal exit always starts an exchange, whatever its mode bit.
// - global enable does not gate the normal-exit flag.
// - any unit range error sets float error flag when its mode bit set.
// - any float error sets float status bit regardless of mode bit.
// - modes, flags and status live in their context block fields.
// - every exchange sets the global interrupt-mode enable.

module xfi_exit_flags #(
  parameter NFPU  = 4,
  parameter PBITS = 2,
  parameter DW    = 32
) (
  input  wire             clock,
  input  wire             reset,
  input  wire             clk_en,
  // instruction issue and floating-point units
  input  wire             issue_valid,
  input  wire [15:0]      issue_opcode,
  input  wire [NFPU-1:0]  fp_range_err,
  output wire             issue_hold,
  // exchange mechanism
  output reg              exch_req_q,
  input  wire             exch_ack,
  input  wire [PBITS-1:0] exch_next_prog,
  output reg              exch_done_q,
  // classic wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [7:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  output wire             irq
);

  localparam AW = PBITS + 4;

  localparam ST_IDLE   = 3'd0;
  localparam ST_REQ    = 3'd1;
  localparam ST_WR_FLG = 3'd2;
  localparam ST_WR_STA = 3'd3;
  localparam ST_WR_MOD = 3'd4;
  localparam ST_RD_MOD = 3'd5;
  localparam ST_LOAD   = 3'd6;

  reg  [2:0]                state_q;
  reg  [2:0]                state_d;
  reg  [PBITS-1:0]          prog_q;
  reg  [PBITS-1:0]          next_prog_q;
  reg  [`XFI_MODE_BITS-1:0] modes_q;
  reg  [`XFI_FLAG_BITS-1:0] flags_q;
  reg                       fpstat_q;
  reg  [`XFI_EV_BITS-1:0]   ev_status_q;
  reg  [`XFI_EV_BITS-1:0]   ev_enable_q;
  reg  [`XFI_FLAG_BITS-1:0] saved_flags_q;
  reg                       saved_stat_q;
  reg                       fp_late_q;

  reg                       mem_wr;
  reg                       mem_rd;
  reg  [AW-1:0]             mem_addr;
  reg  [DW-1:0]             mem_wdata;
  wire [DW-1:0]             mem_rdata;

  wire                      wb_req;
  wire                      wb_wr;
  wire                      err_exit;
  wire                      norm_exit;
  wire                      any_fp_err;
  wire                      set_err_flag;
  wire                      set_norm_flag;
  wire                      set_fp_flag;
  wire [`XFI_EV_BITS-1:0]   ev_set;
  wire [`XFI_EV_BITS-1:0]   ev_clr;
  wire                      wr_modes;
  wire                      wr_enable;
  wire                      wr_clear;
  wire                      exch_taken;
  wire                      ctx_load;
  wire                      late_window;

  // context address of one field of one program
  function [AW-1:0] ctx_addr;
    input [PBITS-1:0] prog;
    input [3:0]       word;
    begin
      ctx_addr = {prog, word};
    end
  endfunction

  // byte-lane merge, used only for the program register read with all lanes selected
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    integer      i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // register write strobe, taken at the acknowledging edge
  function reg_wr_hit;
    input       wr;
    input [7:0] adr;
    input [3:0] sel;
    input [7:0] offset;
    begin
      reg_wr_hit = wr && (adr == offset) && sel[0];
    end
  endfunction

  xfi_ctx_mem #(
    .DW (DW),
    .AW (AW)
  ) u_ctx_mem (
    .clock   (clock),
    .clk_en  (clk_en),
    .wr_en   (mem_wr),
    .rd_en   (mem_rd),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  );

  // exit instructions are taken only while no exchange is running
  assign issue_hold = (state_q != ST_IDLE);
  assign err_exit   = issue_valid && !issue_hold && (issue_opcode == `XFI_OP_ERR_EXIT);
  assign norm_exit  = issue_valid && !issue_hold && (issue_opcode == `XFI_OP_NORM_EXIT);
  assign any_fp_err = |fp_range_err;

  // sequencer events used in several processes
  assign exch_taken  = (state_q == ST_REQ) && exch_ack;
  assign ctx_load    = (state_q == ST_LOAD);
  // float errors after the status word is saved belong to the next interval
  assign late_window = (state_q == ST_WR_STA) || (state_q == ST_WR_MOD) || (state_q == ST_RD_MOD);

  assign set_err_flag  = err_exit && modes_q[`XFI_MODE_ERR_EXIT_EN] && modes_q[`XFI_MODE_GLOBAL_EN];
  assign set_norm_flag = norm_exit && modes_q[`XFI_MODE_NORM_EXIT_EN];
  assign set_fp_flag   = any_fp_err && modes_q[`XFI_MODE_FLOAT_EN];

  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr  = wb_req && wb_we_i && wb_ack_o;

  // register write strobes
  assign wr_modes  = reg_wr_hit(wb_wr, wb_adr_i, wb_sel_i, `XFI_REG_MODES);
  assign wr_enable = reg_wr_hit(wb_wr, wb_adr_i, wb_sel_i, `XFI_REG_ENABLE);
  assign wr_clear  = reg_wr_hit(wb_wr, wb_adr_i, wb_sel_i, `XFI_REG_CLEAR);

  assign ev_set = {exch_done_q, set_fp_flag, set_norm_flag, set_err_flag};
  assign ev_clr = wr_clear ? wb_dat_i[`XFI_EV_BITS-1:0]
                           : {`XFI_EV_BITS{1'b0}};
  assign irq    = |(ev_status_q & ev_enable_q);

  // exchange sequencer
  always @* begin
    state_d   = state_q;
    mem_wr    = 1'b0;
    mem_rd    = 1'b0;
    mem_addr  = ctx_addr(prog_q, `XFI_CTX_W_FLAGS);
    mem_wdata = {DW{1'b0}};
    case (state_q)
      ST_IDLE: begin
        if (err_exit || norm_exit) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (exch_ack) begin
          state_d = ST_WR_FLG;
        end
      end
      ST_WR_FLG: begin
        mem_wr    = 1'b1;
        mem_addr  = ctx_addr(prog_q, `XFI_CTX_W_FLAGS);
        mem_wdata = {{(DW-`XFI_FLAG_BITS){1'b0}}, flags_q};
        state_d   = ST_WR_STA;
      end
      ST_WR_STA: begin
        mem_wr    = 1'b1;
        mem_addr  = ctx_addr(prog_q, `XFI_CTX_W_STATUS);
        mem_wdata = {{(DW-1){1'b0}}, fpstat_q};
        state_d   = ST_WR_MOD;
      end
      ST_WR_MOD: begin
        mem_wr    = 1'b1;
        mem_addr  = ctx_addr(prog_q, `XFI_CTX_W_MODES);
        mem_wdata = {{(DW-`XFI_MODE_BITS){1'b0}}, modes_q};
        state_d   = ST_RD_MOD;
      end
      ST_RD_MOD: begin
        mem_rd   = 1'b1;
        mem_addr = ctx_addr(next_prog_q, `XFI_CTX_W_MODES);
        state_d  = ST_LOAD;
      end
      ST_LOAD: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      state_q     <= ST_IDLE;
      prog_q      <= {PBITS{1'b0}};
      next_prog_q <= {PBITS{1'b0}};
      exch_req_q  <= 1'b0;
      exch_done_q <= 1'b0;
    end else if (clk_en) begin
      state_q     <= state_d;
      exch_done_q <= ctx_load;
      if (state_q == ST_IDLE && state_d == ST_REQ) begin
        exch_req_q <= 1'b1;
      end else if (exch_taken) begin
        exch_req_q  <= 1'b0;
        next_prog_q <= exch_next_prog;
      end
      if (ctx_load) begin
        prog_q <= next_prog_q;
      end
    end
  end

  // mode bits, interrupt flags and float status of the running program
  always @(posedge clock) begin
    if (reset) begin
      modes_q  <= `XFI_MODE_RESET;
      flags_q  <= {`XFI_FLAG_BITS{1'b0}};
      fpstat_q <= 1'b0;
    end else if (clk_en) begin
      if (ctx_load) begin
        modes_q                      <= mem_rdata[`XFI_MODE_BITS-1:0];
        modes_q[`XFI_MODE_GLOBAL_EN] <= 1'b1;
        flags_q                      <= {`XFI_FLAG_BITS{1'b0}};
        // an error in the load cycle or from the status write on opens the new interval set
        flags_q[`XFI_FLAG_FLOAT_ERR] <= (any_fp_err || fp_late_q) && mem_rdata[`XFI_MODE_FLOAT_EN];
        fpstat_q                     <= any_fp_err || fp_late_q;
      end else begin
        if (wr_modes) begin
          modes_q <= wb_dat_i[`XFI_MODE_BITS-1:0];
        end
        if (exch_taken) begin
          modes_q[`XFI_MODE_GLOBAL_EN] <= 1'b1;
        end
        if (set_err_flag) begin
          flags_q[`XFI_FLAG_ERR_EXIT] <= 1'b1;
        end
        if (set_norm_flag) begin
          flags_q[`XFI_FLAG_NORM_EXIT] <= 1'b1;
        end
        if (set_fp_flag) begin
          flags_q[`XFI_FLAG_FLOAT_ERR] <= 1'b1;
        end
        if (any_fp_err) begin
          fpstat_q <= 1'b1;
        end
      end
    end
  end

  // float errors seen from the status write to the mode read of the exchange
  always @(posedge clock) begin
    if (reset) begin
      fp_late_q <= 1'b0;
    end else if (clk_en) begin
      if (ctx_load) begin
        fp_late_q <= 1'b0;
      end else if (late_window && any_fp_err) begin
        fp_late_q <= 1'b1;
      end
    end
  end

  // last flags and status words written back to the outgoing block
  always @(posedge clock) begin
    if (reset) begin
      saved_flags_q <= {`XFI_FLAG_BITS{1'b0}};
      saved_stat_q  <= 1'b0;
    end else if (clk_en) begin
      if (state_q == ST_WR_FLG) begin
        saved_flags_q <= mem_wdata[`XFI_FLAG_BITS-1:0];
      end
      if (state_q == ST_WR_STA) begin
        saved_stat_q <= mem_wdata[`XFI_STAT_FLOAT_ERR];
      end
    end
  end

  // sticky event status, set wins over clear
  always @(posedge clock) begin
    if (reset) begin
      ev_status_q <= {`XFI_EV_BITS{1'b0}};
      ev_enable_q <= {`XFI_EV_BITS{1'b0}};
    end else if (clk_en) begin
      ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
      if (wr_enable) begin
        ev_enable_q <= wb_dat_i[`XFI_EV_BITS-1:0];
      end
    end
  end

  // wishbone answer, one wait state
  always @(posedge clock) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          `XFI_REG_STATUS: wb_dat_o <= {{(32-`XFI_EV_BITS){1'b0}}, ev_status_q};
          `XFI_REG_ENABLE: wb_dat_o <= {{(32-`XFI_EV_BITS){1'b0}}, ev_enable_q};
          `XFI_REG_MODES:  wb_dat_o <= {{(32-`XFI_MODE_BITS){1'b0}}, modes_q};
          `XFI_REG_FLAGS:  wb_dat_o <= {{(32-`XFI_FLAG_BITS){1'b0}}, flags_q};
          `XFI_REG_FPSTAT: wb_dat_o <= {31'h0000_0000, fpstat_q};
          `XFI_REG_PROG:   wb_dat_o <= lane_merge(32'h0000_0000, {{(32-PBITS){1'b0}}, prog_q}, 4'hF);
          // words saved by the last exchange
          `XFI_REG_SAVED_FLAGS: wb_dat_o <= {{(32-`XFI_FLAG_BITS){1'b0}}, saved_flags_q};
          `XFI_REG_SAVED_STAT:  wb_dat_o <= {31'h0000_0000, saved_stat_q};
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // xfi_exit_flags

// >>> bench/xfi_exit_flags_assertions.sv
`timescale 1ns/1ps

module xfi_exit_flags_chk (
  input logic        clock,
  input logic        reset,
  input logic        clk_en,
  input logic        issue_valid,
  input logic [15:0] issue_opcode,
  input logic        issue_hold,
  input logic        exch_req_q,
  input logic        exch_ack,
  input logic        exch_done_q,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  AST_ERR_EXIT_REQ: assert property (clk_en && issue_valid && !issue_hold && issue_opcode == 16'h0000 |=> exch_req_q)
    else $error("error exit did not request an exchange");
  AST_NORM_EXIT_REQ: assert property (clk_en && issue_valid && !issue_hold && issue_opcode == 16'h0800 |=> exch_req_q)
    else $error("normal exit did not request an exchange");
  AST_REQ_HOLDS: assert property (exch_req_q |-> issue_hold)
    else $error("exchange pending without issue hold");
  AST_REQ_CAUSE: assert property ($rose(exch_req_q) |-> $past(issue_valid))
    else $error("exchange requested without an issued exit");
  AST_REQ_DROP: assert property (clk_en && exch_req_q && exch_ack |=> !exch_req_q)
    else $error("exchange request stayed up after ack");
  AST_DONE_TIME: assert property (clk_en && exch_req_q && exch_ack |-> ##[5:7] exch_done_q)
    else $error("exchange did not complete in time");
  AST_DONE_PULSE: assert property (clk_en && exch_done_q |=> !exch_done_q)
    else $error("exchange done longer than one cycle");
  AST_WB_ACK: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  AST_ACK_ONE: assert property (clk_en && wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
endmodule // xfi_exit_flags_chk

bind xfi_exit_flags xfi_exit_flags_chk xfi_exit_flags_chk_inst (.clock, .reset, .clk_en, .issue_valid, .issue_opcode,
  .issue_hold, .exch_req_q, .exch_ack, .exch_done_q, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// >>> bench/xfi_exch_model.sv
`timescale 1ns/1ps

module xfi_exch_model (
  input  logic       clock,
  input  logic       reset,
  input  logic       exch_req_q,
  output logic       exch_ack,
  output logic [1:0] exch_next_prog
);
  logic [2:0] cnt_q;
  logic [2:0] dly_q;

  // answers each request after a random wait; prog lines churn when idle
  always @(posedge clock) begin
    exch_ack <= 1'b0;
    exch_next_prog <= ~exch_next_prog;
    if (reset) begin
      cnt_q <= 3'h0;
      dly_q <= 3'h0;
      exch_next_prog <= 2'h0;
    end else if (exch_req_q && !exch_ack) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == dly_q) begin
        exch_ack <= 1'b1;
        exch_next_prog <= 2'h0; // same program reloads its own block
        cnt_q <= 3'h0;
        dly_q <= 3'($urandom_range(0, 6));
      end
    end
  end
endmodule // xfi_exch_model

// >>> bench/xfi_exit_flags_bench.sv
`timescale 1ns/1ps
`include "xfi_defines.vh"

module xfi_exit_flags_bench;
  logic        clock, reset, clk_en, issue_valid, wb_cyc_i, wb_stb_i, wb_we_i;
  logic        issue_hold, exch_req_q, exch_ack, exch_done_q, wb_ack_o, irq, op_err;
  logic [15:0] issue_opcode;
  logic [3:0]  fp_range_err, wb_sel_i, m, en;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, e_st;
  logic [1:0]  exch_next_prog, u;
  int          err_count, n_tests, n;

  xfi_exit_flags xfi_exit_flags_inst (.clock, .reset, .clk_en, .issue_valid, .issue_opcode, .fp_range_err,
    .issue_hold, .exch_req_q, .exch_ack, .exch_next_prog, .exch_done_q, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq);
  xfi_exch_model xfi_exch_model_inst (.clock, .reset, .exch_req_q, .exch_ack, .exch_next_prog);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task close_out;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task limit_hit;
    err_count++;
    $display("ERROR t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
    close_out;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 50) limit_hit;
  endtask

  // sticky status after one exit and one float error
  function logic [31:0] exp_status(input logic [3:0] md, input logic e);
    return {28'h000_0000, 1'b1, md[2], ~e & md[1], e & md[0] & md[3]};
  endfunction

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    issue_valid = 1'b0;
    issue_opcode = 16'h1000;
    fp_range_err = 4'h0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'h0000_99ce));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    wb(0, `XFI_REG_MODES, 0);
    chk(rd, 32'h0000_0000);
    wb(0, 8'h24, 0);
    chk(rd, 32'h0000_0000);
    clk_en <= 1'b0;
    fp_range_err <= 4'h2;
    repeat (2) @(posedge clock);
    fp_range_err <= 4'h0;
    clk_en <= 1'b1;
    wb(0, `XFI_REG_FPSTAT, 0);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      en = 4'($urandom);
      op_err = 1'($urandom);
      u = 2'($urandom);
      wb(1, `XFI_REG_CLEAR, 32'h0000_000f);
      wb(1, `XFI_REG_MODES, {28'h000_0000, m});
      wb(1, `XFI_REG_ENABLE, {28'h000_0000, en});
      @(posedge clock);
      fp_range_err <= 4'h1 << u;
      @(posedge clock);
      fp_range_err <= 4'h0;
      wb(0, `XFI_REG_FLAGS, 0);
      chk(rd, {29'h0000_0000, m[2], 2'b00});
      wb(0, `XFI_REG_FPSTAT, 0);
      chk(rd, 32'h0000_0001);
      @(posedge clock);
      issue_valid <= 1'b1;
      issue_opcode <= op_err ? `XFI_OP_ERR_EXIT : `XFI_OP_NORM_EXIT;
      @(posedge clock);
      issue_valid <= 1'b0;
      issue_opcode <= 16'h1000 | 16'($urandom);
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (exch_done_q !== 1'b1 && n < 60);
      if (n >= 60) limit_hit;
      e_st = exp_status(m, op_err);
      wb(0, `XFI_REG_STATUS, 0);
      chk(rd, e_st);
      chk({31'h0, irq}, {31'h0, |(e_st[3:0] & en)});
      wb(0, `XFI_REG_SAVED_FLAGS, 0);
      chk(rd, {29'h0000_0000, e_st[2:0]});
      wb(0, `XFI_REG_SAVED_STAT, 0);
      chk(rd, 32'h0000_0001);
      wb(0, `XFI_REG_FLAGS, 0);
      chk(rd, 32'h0000_0000);
      wb(0, `XFI_REG_FPSTAT, 0);
      chk(rd, 32'h0000_0000);
      wb(0, `XFI_REG_PROG, 0);
      chk(rd, 32'h0000_0000);
      wb(0, `XFI_REG_MODES, 0);
      chk(rd, {28'h000_0000, m | 4'h8});
      wb(1, `XFI_REG_CLEAR, 32'h0000_000f);
      wb(0, `XFI_REG_STATUS, 0);
      chk({rd[31:1], irq}, 32'h0000_0000);
      $display("test exit %0d done", i);
    end
    close_out;
  end
endmodule // xfi_exit_flags_bench
